// ### hdl/watchdog_and_reset_flags.sv
// Watchdog timer with keyed restart and battery-backed reset-source flags.
// Assumes the front end gives one-cycle reg strobes; supervisor pins are asynchronous.
// Behaviour
// RL1 - Five-bit code sets timeout in 100 ms steps; all ones disables; zero invalid.
// RL2 - Writing key 1010b restarts timer; new timeout code loaded only then.
// RL3 - Timeout code is held in nonvolatile storage, readable and writable.
// RL4 - Watchdog expiry driving reset sets the watchdog-reset flag.
// RL5 - Supply below trip voltage driving reset sets the power-reset flag.
// RL6 - The two reset-source flags are independent and may both be set.
// RL7 - Backup supply low at power-up sets the low-backup flag.
// RL8 - Host software should clear the low-backup flag during initialisation.
// RL9 - Only hardware sets flags; software writes can only clear them.
// RL10 - Status flags live in battery-backed storage across main supply loss.
// RL11 - Counter runs regardless of enable; expiry resets only when enabled.
// RL12 - Non-key restart values do nothing; flags writable without restart.
`timescale 1ns/1ns
module watchdog_and_reset_flags
    import dog_pkg::*;
#(
    parameter longint STEP_CYCLES  = dog_pkg::STEP_CYCLES,
    parameter longint PULSE_CYCLES = dog_pkg::PULSE_CYCLES
) (
    // Clock and reset; rst_n_in is the battery-domain reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // Register port
    input  wire dog_pkg::reg_req_t reg_req_in,
    output logic [7:0]            reg_rdata_out,
    // Supervisor inputs (asynchronous)
    input  wire logic             supply_low_in,
    input  wire logic             backup_low_at_powerup_in,
    input  wire logic             power_up_in,
    // Reset output and status flags
    output logic                  reset_n_out,
    output dog_pkg::flags_t       flags_out
);
    import dog_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       supply_low_s;
    logic       backup_low_s;
    logic       power_up_s;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {supply_low_in, backup_low_at_powerup_in, power_up_in};
            sync_b <= sync_a;
        end
    end

    assign supply_low_s = sync_b[2];
    assign backup_low_s = sync_b[1];
    assign power_up_s   = sync_b[0];

    // ************************************************************
    // Register decode
    // ************************************************************
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : hit

    // Code zero is out of range; it runs as the one-step interval so a bad setup
    // still leaves the host a chance to restart instead of an instant reset
    function automatic logic [TIMEOUT_CODE_W-1:0] steps_needed(
        input logic [TIMEOUT_CODE_W-1:0] c
    );
        return (c == TIMEOUT_CODE_BAD) ? TIMEOUT_CODE_W'(1) : c;
    endfunction : steps_needed

    logic wr_flags;
    logic wr_setup;
    logic restart;

    assign wr_flags = hit(reg_req_in, ADDR_RESTART_AND_RESET_FLAGS);
    assign wr_setup = hit(reg_req_in, ADDR_WATCHDOG_SETUP);
    // Other nibble values are ignored so flag clears never kick the dog [RL12]
    assign restart  = wr_flags
                   && reg_req_in.wdata[RESTART_KEY_W-1:0] == RESTART_KEY_VALUE; // [RL2]

    // ************************************************************
    // Setup register (nonvolatile store modelled by battery-domain flops)
    // ************************************************************
    logic                      dog_reset_enable;
    logic [TIMEOUT_CODE_W-1:0] timeout_code;
    logic [TIMEOUT_CODE_W-1:0] active_code;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dog_reset_enable <= DOG_ENABLE_RESET;
            timeout_code     <= TIMEOUT_CODE_RESET;
        end else if (wr_setup) begin
            dog_reset_enable <= reg_req_in.wdata[BIT_DOG_RESET_ENABLE];
            timeout_code     <= reg_req_in.wdata[TIMEOUT_CODE_W-1:0]; // [RL3]
        end
    end

    // Written code only reaches the counter at a keyed restart
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_code <= TIMEOUT_CODE_RESET;
        end else if (restart) begin
            active_code <= timeout_code; // [RL2]
        end
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    logic                      tick;
    logic [TIMEOUT_CODE_W-1:0] steps;
    logic                      expire;
    logic                      code_off;

    dog_step_tick #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_tick (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .restart_in (restart),
        .tick_out   (tick)
    );

    // Invalid code zero is treated as the shortest step rather than firing at once
    assign code_off = (active_code == TIMEOUT_CODE_OFF); // [RL1]
    assign expire   = tick && !code_off
                   && (steps + 5'h01 >= steps_needed(active_code)); // [RL1]

    // Free running: expiry restarts the count whatever the enable says [RL11]
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            steps <= 5'h00;
        end else if (restart || expire) begin
            steps <= 5'h00;
        end else if (tick && !code_off) begin
            steps <= steps + 5'h01;
        end
    end

    // ************************************************************
    // Reset pulse
    // ************************************************************
    localparam int PW = $clog2(PULSE_CYCLES + 1);
    logic [PW-1:0] pulse_count;
    logic          dog_fire;

    assign dog_fire = expire && dog_reset_enable; // [RL11]

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_count <= '0;
        end else if (dog_fire) begin
            pulse_count <= PW'(PULSE_CYCLES);
        end else if (pulse_count != '0) begin
            pulse_count <= pulse_count - PW'(1);
        end
    end

    // Supply-low reset lasts as long as the low condition, stretched by the supervisor
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reset_n_out <= 1'b1;
        end else begin
            reset_n_out <= !(dog_fire || pulse_count > PW'(1) || supply_low_s);
        end
    end

    // ************************************************************
    // Battery-backed status flags
    // ************************************************************
    localparam int N_FLAGS = 3;

    logic               power_up_d;
    logic               power_up_rise;
    logic [N_FLAGS-1:0] flag_set;
    logic [N_FLAGS-1:0] flag_keep;
    logic [N_FLAGS-1:0] flag_q;
    flags_t             flags;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_up_d <= 1'b0;
        end else begin
            power_up_d <= power_up_s;
        end
    end

    // Edge taken on the synchronised copy only, so one power-up gives one rise;
    // the release of the battery reset with power present counts as a power-up
    assign power_up_rise = power_up_s && !power_up_d;

    // Hardware causes, in the bit order of the flag carrier
    assign flag_set[2] = dog_fire;                      // [RL4] [RL6]
    assign flag_set[1] = supply_low_s;                  // [RL5] [RL6]
    assign flag_set[0] = power_up_rise && backup_low_s; // [RL7]

    // A flag write keeps a flag where its bit is one; software can never set one
    assign flag_keep[2] = !wr_flags || reg_req_in.wdata[BIT_DOG_CAUSED_RESET]; // [RL9]
    assign flag_keep[1] = !wr_flags || reg_req_in.wdata[BIT_POWER_RESET];      // [RL9]
    assign flag_keep[0] = !wr_flags || reg_req_in.wdata[BIT_BACKUP_LOW];       // [RL9]

    // Set beats clear in one cycle, so a cause is never lost to a racing clear.
    // Cleared by software writes or the battery-domain reset, not by main supply loss [RL10]
    for (genvar g = 0; g < N_FLAGS; g++) begin : g_flag
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                flag_q[g] <= 1'b0;
            end else if (flag_set[g]) begin
                flag_q[g] <= 1'b1;
            end else if (!flag_keep[g]) begin
                flag_q[g] <= 1'b0;
            end
        end
    end

    assign flags     = flags_t'(flag_q);
    assign flags_out = flags;

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                ADDR_RESTART_AND_RESET_FLAGS: begin
                    reg_rdata_out <= {flags.dog_caused_reset_flag, flags.power_reset_flag,
                                      flags.backup_low_flag, 5'h00};
                end
                ADDR_WATCHDOG_SETUP: begin
                    reg_rdata_out <= {dog_reset_enable, 2'h0, timeout_code}; // [RL3]
                end
                default: begin
                    reg_rdata_out <= 8'h00;
                end
            endcase
        end
    end
endmodule : watchdog_and_reset_flags

// ### hdl/dog_pkg.sv
// Constants, field layouts and carrier types of the watchdog and reset-flag block.
// Assumes a 250 MHz system clock and a byte-wide register port from the serial front end.
package dog_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_RESTART_AND_RESET_FLAGS = 8'h09;
    localparam logic [7:0] ADDR_WATCHDOG_SETUP          = 8'h0A;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_DOG_CAUSED_RESET = 7;
    localparam int BIT_POWER_RESET      = 6;
    localparam int BIT_BACKUP_LOW       = 5;
    localparam int BIT_DOG_RESET_ENABLE = 7;
    localparam int TIMEOUT_CODE_W       = 5;
    localparam int RESTART_KEY_W        = 4;

    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [3:0] RESTART_KEY_VALUE   = 4'hA;
    localparam logic [4:0] TIMEOUT_CODE_OFF    = 5'h1F;
    localparam logic [4:0] TIMEOUT_CODE_BAD    = 5'h00;
    localparam logic [4:0] TIMEOUT_CODE_RESET  = 5'h01;
    localparam logic       DOG_ENABLE_RESET    = 1'b0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam longint CLK_HZ          = 250_000_000;
    localparam longint STEP_MS         = 100;
    localparam longint STEP_CYCLES     = (CLK_HZ / 1000) * STEP_MS;
    localparam longint RESET_PULSE_MS  = 100;
    localparam longint PULSE_CYCLES    = (CLK_HZ / 1000) * RESET_PULSE_MS;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic dog_caused_reset_flag;
        logic power_reset_flag;
        logic backup_low_flag;
    } flags_t;

endpackage : dog_pkg

// ### hdl/dog_step_tick.sv
// Divider producing one pulse per 100 ms time-base step.
// Assumes it runs on the system clock; restart realigns the phase.
`timescale 1ns/1ns
module dog_step_tick #(
    parameter longint STEP_CYCLES = 25_000_000
) (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic restart_in,
    output logic      tick_out
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

    logic [CW-1:0] count;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= '0;
        end else if (restart_in || count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    assign tick_out = (count == LAST) && !restart_in;
endmodule : dog_step_tick

// ### verif/dog_properties.sv
// Port-level assertions for the watchdog and reset-flag block.
// Assumes it is bound to the top module with the same count parameters.
`timescale 1ns/1ns
module dog_properties
    import dog_pkg::*;
#(
    parameter longint STEP_CYCLES  = 10,
    parameter longint PULSE_CYCLES = 5
) (
    // Clock and reset
    input wire logic              clk_sys_in,
    input wire logic              rst_n_in,
    // Watched ports
    input wire dog_pkg::reg_req_t reg_req_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              supply_low_in,
    input wire logic              backup_low_at_powerup_in,
    input wire logic              power_up_in,
    input wire logic              reset_n_out,
    input wire dog_pkg::flags_t   flags_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // ************************************************************
    // Shadow of the timer; quiet gates out supply-caused resets
    // ************************************************************
    logic [31:0] low_cnt;
    logic [31:0] quiet;
    logic [31:0] since;
    logic [31:0] span;
    logic [4:0]  code;
    logic [4:0]  act;
    logic        en;
    logic        armed;
    logic        key;
    assign key  = reg_req_in.wr && reg_req_in.addr == ADDR_RESTART_AND_RESET_FLAGS
                  && reg_req_in.wdata[3:0] == RESTART_KEY_VALUE;
    assign span = (act == 5'h00 ? 32'h1 : 32'(act)) * 32'(STEP_CYCLES);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cnt <= '0;
            quiet   <= '0;
            since   <= '0;
            code    <= TIMEOUT_CODE_RESET;
            act     <= TIMEOUT_CODE_RESET;
            en      <= DOG_ENABLE_RESET;
            armed   <= 1'b0;
        end else begin
            low_cnt <= reset_n_out ? '0 : low_cnt + 32'h1;
            quiet   <= supply_low_in ? '0 : quiet + 32'h1;
            since   <= key ? '0 : since + 32'h1 - ($fell(reset_n_out) ? span : '0);
            if (reg_req_in.wr && reg_req_in.addr == ADDR_WATCHDOG_SETUP) begin
                code <= reg_req_in.wdata[4:0];
                en   <= reg_req_in.wdata[BIT_DOG_RESET_ENABLE];
            end
            if (key) begin
                act <= code;
            end
            armed <= key ? en : armed && en;
        end
    end
    property p_expiry_time;
        $fell(reset_n_out) && quiet > 32'h8 && armed |-> since >= span && since <= span + 32'h2;
    endproperty
    a_expiry_time: assert property (p_expiry_time)
        else $error("watchdog expiry outside its interval");
    property p_enable_gate;
        $fell(reset_n_out) && quiet > 32'h8 |-> en && act != TIMEOUT_CODE_OFF;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("reset from a disabled watchdog");
    property p_pulse_len;
        $rose(reset_n_out) && quiet > 32'h10 |-> low_cnt == 32'(PULSE_CYCLES);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("watchdog reset pulse length wrong");
    property p_dog_flag;
        $fell(reset_n_out) && quiet > 32'h8 |-> ##[0:1] flags_out.dog_caused_reset_flag;
    endproperty
    a_dog_flag: assert property (p_dog_flag)
        else $error("watchdog reset without its flag");
    property p_dog_flag_cause;
        $rose(flags_out.dog_caused_reset_flag) |-> !reset_n_out;
    endproperty
    a_dog_flag_cause: assert property (p_dog_flag_cause)
        else $error("watchdog flag set without a reset");
    property p_power_flag;
        supply_low_in [*4] |=> flags_out.power_reset_flag && !reset_n_out;
    endproperty
    a_power_flag: assert property (p_power_flag)
        else $error("low supply did not reset and flag");
    property p_power_cause;
        $rose(flags_out.power_reset_flag) |->
            $past(supply_low_in, 2) || $past(supply_low_in, 3) || $past(supply_low_in, 4);
    endproperty
    a_power_cause: assert property (p_power_cause)
        else $error("power flag set without low supply");
    property p_backup_cause;
        $rose(flags_out.backup_low_flag) |->
            $past(backup_low_at_powerup_in, 3) || $past(backup_low_at_powerup_in, 4);
    endproperty
    a_backup_cause: assert property (p_backup_cause)
        else $error("backup flag set without low backup");
    property p_read_setup;
        reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == ADDR_WATCHDOG_SETUP
            |=> reg_rdata_out == {en, 2'h0, code};
    endproperty
    a_read_setup: assert property (p_read_setup)
        else $error("setup register read back wrong");
    c_dog_reset: cover property ($fell(reset_n_out) && armed);
    c_both_flags: cover property (flags_out.power_reset_flag && flags_out.dog_caused_reset_flag);
    c_backup: cover property ($rose(flags_out.backup_low_flag));
endmodule : dog_properties

bind watchdog_and_reset_flags dog_properties #(
    .STEP_CYCLES(STEP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) i_props (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .supply_low_in(supply_low_in),
    .backup_low_at_powerup_in(backup_low_at_powerup_in), .power_up_in(power_up_in),
    .reset_n_out(reset_n_out), .flags_out(flags_out));

// ### verif/dog_host.sv
// Host processor model: byte register accesses to the watchdog block.
// Assumes every task is entered just after a rising clock edge.
`timescale 1ns/1ns
module dog_host
    import dog_pkg::*;
(
    // Clock
    input  wire logic         clk_sys_in,
    // Register port
    output dog_pkg::reg_req_t req_out,
    input  wire logic [7:0]   rdata_in
);
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_in);
        req_out <= '0;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_in);
        req_out <= '0;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        d = rdata_in;
        @(posedge clk_sys_in);
    endtask : rd
    // Flag bits written as ones so a restart never clears them
    task automatic restart();
        wr(ADDR_RESTART_AND_RESET_FLAGS, 8'hEA);
    endtask : restart
    task automatic clear_flags();
        wr(ADDR_RESTART_AND_RESET_FLAGS, 8'h00);
    endtask : clear_flags
endmodule : dog_host

// ### verif/test_watchdog_and_reset_flags.sv
// Self-checking bench for the watchdog and reset-flag block.
// Assumes shortened step and pulse counts so the run stays short.
`timescale 1ns/1ns
module test_watchdog_and_reset_flags;
    import dog_pkg::*;
    localparam longint STEP  = 10;
    localparam longint PULSE = 5;
    logic              clk_sys_in;
    logic              rst_n_in;
    logic              supply_low;
    logic              backup_low;
    logic              power_up;
    dog_pkg::reg_req_t req;
    logic [7:0]        rdata;
    logic              reset_n;
    dog_pkg::flags_t   flags;
    logic [7:0]        v;
    int                errors = 0;
    int                n_tests = 0;
    int                lows = 0;
    dog_host i_host (.clk_sys_in(clk_sys_in), .req_out(req), .rdata_in(rdata));
    watchdog_and_reset_flags #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .supply_low_in(supply_low),
        .backup_low_at_powerup_in(backup_low), .power_up_in(power_up),
        .reset_n_out(reset_n), .flags_out(flags));
    always @(negedge clk_sys_in) if (!reset_n) lows++;
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic t_regs();
        i_host.rd(ADDR_WATCHDOG_SETUP, v);
        chk("setup reset", 8'h01, v);
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h7E);
        i_host.rd(ADDR_WATCHDOG_SETUP, v);
        chk("setup rw", 8'h1E, v);
        i_host.rd(8'h0B, v);
        chk("unmapped", 8'h00, v);
    endtask : t_regs
    task automatic t_dog();
        longint t0;
        longint k;
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h02);
        i_host.restart();
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h82);
        i_host.restart();
        t0 = $time - 4;
        i_host.rd(ADDR_RESTART_AND_RESET_FLAGS, v);
        chk("no set by write", 8'h00, v);
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h85);
        i_host.wr(ADDR_RESTART_AND_RESET_FLAGS, 8'hE5);
        for (int i = 0; i < 100 && reset_n; i++) @(negedge clk_sys_in);
        k = ($time - t0) / 4;
        chk("expiry time", 8'h01, {7'h0, k >= 2 * STEP && k <= 2 * STEP + 2});
        for (int i = 0; i < 50 && !reset_n; i++) @(posedge clk_sys_in);
        chk("dog flag", 8'h80, {flags, 5'h00});
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h1F);
    endtask : t_dog
    task automatic t_off();
        int n;
        i_host.restart();
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h9F);
        n = lows;
        repeat (100) @(posedge clk_sys_in);
        chk("code off", 8'h00, 8'(lows - n));
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h01);
        i_host.restart();
        repeat (40) @(posedge clk_sys_in);
        chk("enable off", 8'h00, 8'(lows - n));
    endtask : t_off
    task automatic t_zero();
        longint t0;
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h80);
        i_host.restart();
        t0 = $time - 4;
        for (int i = 0; i < 40 && reset_n; i++) @(negedge clk_sys_in);
        chk("code zero", 8'h01, {7'h0, ($time - t0) / 4 == STEP});
        i_host.wr(ADDR_WATCHDOG_SETUP, 8'h01);
        for (int i = 0; i < 50 && !reset_n; i++) @(posedge clk_sys_in);
    endtask : t_zero
    task automatic t_power();
        supply_low <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        chk("power reset", 8'h00, {7'h0, reset_n});
        supply_low <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        i_host.rd(ADDR_RESTART_AND_RESET_FLAGS, v);
        chk("both flags", 8'hC0, v);
        i_host.clear_flags();
        i_host.rd(ADDR_RESTART_AND_RESET_FLAGS, v);
        chk("flags cleared", 8'h00, v);
    endtask : t_power
    task automatic t_backup();
        power_up   <= 1'b0;
        backup_low <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        power_up <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        i_host.rd(ADDR_RESTART_AND_RESET_FLAGS, v);
        chk("backup flag", 8'h20, v);
        backup_low <= 1'b0;
        i_host.clear_flags();
        i_host.rd(ADDR_RESTART_AND_RESET_FLAGS, v);
        chk("backup cleared", 8'h00, v);
    endtask : t_backup
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #20000;
        errors++;
        stop_test();
    end
    initial begin
        rst_n_in   = 1'b0;
        supply_low = 1'b0;
        backup_low = 1'b0;
        power_up   = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_regs();
        t_dog();
        t_off();
        t_zero();
        t_power();
        t_backup();
        stop_test();
    end
endmodule : test_watchdog_and_reset_flags
